// ### lows_pkg.sv
// lows_pkg: constants, register map and reset values of the wake pin block.
// assumes one 25 MHz system clock and an APB register port.
// Contract
// - while hardware reset is held, the shared pin level becomes the default contender status.
// - after reset ends the shared pin is driven as the wake output to the link layer.
// - while wake is active the pin carries a square wave of eight clock cycles per period.
// - wake inactive drives the pin low, except during reset when the pin is not driven.
// - the link layer is inactive when link power status or the link-active bit is off.
// - a link-on packet addressed to this node starts wake while the link layer is inactive.
// - a set port-event flag starts wake while the link layer is inactive.
// - a set timeout or cable-power flag with the resuming-port enable set starts wake.
// - once started, wake keeps toggling until the link layer is active.
// - a bus reset stops wake unless an enabled interrupt flag still asks for it.
// - link power status counts as inactive only after staying low more than 2.6 us.
// - an interrupt condition pending while the link is active starts wake once it goes inactive.
package lows_pkg;
	// clock and timing
	localparam int CLK_NS          = 40;
	localparam int PWR_LOW_NS      = 2600;  // 2.6 us
	localparam int PWR_LOW_CYC     = (PWR_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_PERIOD_NS  = 163;   // nominal period at the link clock rate
	localparam int WAKE_PERIOD_CYC = 8;
	localparam int WAKE_HALF_CYC   = WAKE_PERIOD_CYC / 2;

	// register byte offsets
	localparam int          ADDR_W     = 8;
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CLEAR  = 8'h08;
	localparam logic [7:0] OFS_IRQEN  = 8'h0C;
	localparam logic [7:0] OFS_STATE  = 8'h10;

	// control register fields
	localparam int   CTRL_LINK_ACT      = 0;
	localparam int   CTRL_RESUME_EN     = 1;
	localparam int   CTRL_CONT          = 2;
	localparam logic CTRL_LINK_ACT_RST  = 1'b0;
	localparam logic CTRL_RESUME_EN_RST = 1'b0;

	// status, clear and enable share this layout
	localparam int NFLAG    = 6;
	localparam int FLG_PORT = 0;
	localparam int FLG_CFG  = 1;
	localparam int FLG_CPS  = 2;
	localparam int FLG_STO  = 3;
	localparam int FLG_LINK_ON = 4;
	localparam int FLG_WAKE = 5;
	localparam logic [NFLAG-1:0] FLAGS_RST = 6'h00;
	localparam logic [NFLAG-1:0] IRQEN_RST = 6'h00;

	// state register fields
	localparam int ST_WAKE  = 0;
	localparam int ST_LINK  = 1;
	localparam int ST_PWR   = 2;
	localparam int ST_STRAP = 3;
	localparam int ST_BYPKT = 4;
endpackage : lows_pkg

// ### lows_lps_filter.sv
// lows_pwr_filter: synchronises the link power status pin and judges it idle.
// assumes the pin is asynchronous to clk_sys; reset is synchronous.
`timescale 1ns/1ps
module lows_pwr_filter
	import lows_pkg::*;
#(
	parameter int LOW_CYC = PWR_LOW_CYC
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic pwrRaw,
	output logic      pwrActive
);
	localparam logic [7:0] LOW_LIM = 8'(LOW_CYC);

	typedef struct packed {
		logic       s1;
		logic       s2;
		logic [7:0] cnt;
		logic       act;
	} lows_flt_t;

	lows_flt_t flt_q, flt_d;

	// low time counts up and saturates one past the limit; any high sample restarts it
	always_comb begin
		flt_d     = flt_q;
		flt_d.s1  = pwrRaw;
		flt_d.s2  = flt_q.s1;
		if (flt_q.s2) begin
			flt_d.cnt = 8'h00;
		end else if (flt_q.cnt <= LOW_LIM) begin
			flt_d.cnt = flt_q.cnt + 8'h01;
		end
		flt_d.act = flt_q.s2 | (flt_d.cnt <= LOW_LIM);
		if (rst) begin
			flt_d.cnt = 8'h00;
			flt_d.act = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		flt_q <= flt_d;
	end

	assign pwrActive = flt_q.act;

	property p_pwr_high;
		@(posedge clk_sys) disable iff (rst)
		flt_q.s2 |=> pwrActive;
	endproperty
	a_pwr_high: assert property (p_pwr_high) else $error("power status high not seen");
endmodule : lows_pwr_filter

// ### lows_wave_gen.sv
// lows_wave_gen: square wave for the wake pin, half period of WAKE_HALF_CYC clocks.
// assumes en is a registered level on clk_sys; output low from the clock edge after en goes low.
`timescale 1ns/1ps
module lows_wave_gen
	import lows_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic en,
	output logic      wave
);
	typedef struct packed {
		logic [1:0] cnt;
		logic       lvl;
	} lows_wav_t;

	localparam logic [1:0] HALF_LAST = 2'(WAKE_HALF_CYC - 1);

	lows_wav_t wav_q, wav_d;

	// restart from low on every activation so the first half period is whole
	always_comb begin
		wav_d = wav_q;
		if (rst || !en) begin
			wav_d.cnt = 2'h0;
			wav_d.lvl = 1'b0;
		end else begin
			wav_d.cnt = wav_q.cnt + 2'h1;
			if (wav_q.cnt == HALF_LAST) begin
				wav_d.lvl = ~wav_q.lvl;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		wav_q <= wav_d;
	end

	assign wave = wav_q.lvl;

	property p_wave_low_start;
		@(posedge clk_sys) disable iff (rst)
		$rose(en) |-> (!wave)[*4];
	endproperty
	a_wave_low_start: assert property (p_wave_low_start) else $error("wave not low at start");

	property p_wave_rise;
		@(posedge clk_sys) disable iff (rst)
		$rose(en) ##1 en[*4] |-> wave;
	endproperty
	a_wave_rise: assert property (p_wave_rise) else $error("wave did not rise after 4");
endmodule : lows_wave_gen

// ### lows_link_on_wake.sv
// lows_link_on_wake: shared contender strap and link-on wake pin with APB registers.
// assumes APB master on clk_sys, pins asynchronous, packet and flag strobes on clk_sys.
`timescale 1ns/1ps
module lows_link_on_wake
	import lows_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// shared contender / wake pin
	input  wire logic              wakePinIn,
	output logic                   wakePinOut,
	output logic                   wakePinOe,
	// link layer power status pin
	input  wire logic              linkPowerStatus,
	// packet decoder and interrupt sources
	input  wire logic              linkOnRx,
	input  wire logic [5:0]        linkOnPhyId,
	input  wire logic [5:0]        nodeId,
	input  wire logic              busReset,
	input  wire logic              portEventSet,
	input  wire logic              configTimeoutSet,
	input  wire logic              cablePowerSet,
	input  wire logic              stateTimeoutSet,
	// to self-identification and interrupt controller
	output logic                   contenderStatus,
	output logic                   irq
);
	typedef struct packed {
		logic             pinS1;
		logic             pinS2;
		logic             strap;
		logic             contender;
		logic             linkCtrl;
		logic             resumeEn;
		logic [NFLAG-1:0] flags;
		logic [NFLAG-1:0] irqEn;
		logic             wake;
		logic             byPkt;
		logic             pinOe;
		logic             pinOut;
		logic             irq;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
	} lows_state_t;

	lows_state_t      state_q;
	lows_state_t      state_d;
	logic             pwrActive;
	logic             waveBit;
	logic             linkActive;
	logic             irqWake;
	logic             pktMatch;
	logic             wakeNext;
	logic             byPktNext;
	logic             apbAcc;
	logic             apbWr;
	logic             hit;
	logic [31:0]      rdVal;
	logic [NFLAG-1:0] flagSet;
	logic [NFLAG-1:0] flagClr;

	// link power status judged idle after a long low stretch
	lows_pwr_filter #(
		.LOW_CYC (PWR_LOW_CYC)
	) uPwrFilter (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.pwrRaw    (linkPowerStatus),
		.pwrActive (pwrActive)
	);

	// square wave source, enabled by the wake latch
	lows_wave_gen uWaveGen (
		.clk_sys (clk_sys),
		.rst     (rst),
		.en      (state_q.wake),
		.wave    (waveBit)
	);

	// link layer state and wake causes
	assign linkActive = pwrActive & state_q.linkCtrl;
	assign irqWake    = state_q.flags[FLG_PORT]
		| (state_q.resumeEn & (state_q.flags[FLG_CFG]
		| state_q.flags[FLG_CPS] | state_q.flags[FLG_STO]));
	assign pktMatch   = linkOnRx & (linkOnPhyId == nodeId);

	// wake latch: start only while the link is idle, hold until it wakes;
	// a bus reset drops a packet-only wake but the interrupt term re-asserts it,
	// and a condition left pending while active fires once the link goes idle
	assign wakeNext = ~linkActive
		& ((state_q.wake & ~(busReset & ~irqWake))
		| irqWake | pktMatch);
	assign byPktNext = ~linkActive & ~irqWake
		& ((state_q.byPkt & ~busReset) | pktMatch);

	// apb: one wait state, then the access completes
	assign apbAcc = psel & penable;
	assign apbWr  = apbAcc & pwrite & state_q.pready;

	// read decode; unmapped addresses answer with an error and zero data
	always_comb begin
		rdVal = 32'h0000_0000;
		hit   = 1'b1;
		if (paddr == OFS_CTRL) begin
			rdVal[CTRL_LINK_ACT]  = state_q.linkCtrl;
			rdVal[CTRL_RESUME_EN] = state_q.resumeEn;
			rdVal[CTRL_CONT]      = state_q.contender;
		end else if (paddr == OFS_STATUS) begin
			rdVal[NFLAG-1:0] = state_q.flags;
		end else if (paddr == OFS_CLEAR) begin
			rdVal = 32'h0000_0000; // write-only, reads zero
		end else if (paddr == OFS_IRQEN) begin
			rdVal[NFLAG-1:0] = state_q.irqEn;
		end else if (paddr == OFS_STATE) begin
			rdVal[ST_WAKE]  = state_q.wake;
			rdVal[ST_LINK]  = linkActive;
			rdVal[ST_PWR]   = pwrActive;
			rdVal[ST_STRAP] = state_q.strap;
			rdVal[ST_BYPKT] = state_q.byPkt;
		end else begin
			hit = 1'b0;
		end
	end

	// sticky event sources and software clears
	always_comb begin
		flagSet           = '0;
		flagSet[FLG_PORT] = portEventSet;
		flagSet[FLG_CFG]  = configTimeoutSet;
		flagSet[FLG_CPS]  = cablePowerSet;
		flagSet[FLG_STO]  = stateTimeoutSet;
		flagSet[FLG_LINK_ON] = pktMatch;
		flagSet[FLG_WAKE] = wakeNext & ~state_q.wake;
		flagClr           = '0;
		if (apbWr && paddr == OFS_CLEAR) begin
			flagClr = pwdata[NFLAG-1:0];
		end
	end

	// next state of the whole block
	always_comb begin
		state_d       = state_q;
		// pin synchroniser; only the second stage is read below
		state_d.pinS1 = wakePinIn;
		state_d.pinS2 = state_q.pinS1;

		// apb answer registered so every bus output comes from a flop
		state_d.pready  = apbAcc & ~state_q.pready;
		state_d.pslverr = apbAcc & ~state_q.pready & ~hit;
		if (apbAcc && !state_q.pready) begin
			state_d.prdata = rdVal;
		end
		if (apbWr && paddr == OFS_CTRL) begin
			state_d.linkCtrl  = pwdata[CTRL_LINK_ACT];
			state_d.resumeEn  = pwdata[CTRL_RESUME_EN];
			state_d.contender = pwdata[CTRL_CONT];
		end
		if (apbWr && paddr == OFS_IRQEN) begin
			state_d.irqEn = pwdata[NFLAG-1:0];
		end

		// a set in the cycle of its clear is kept
		for (int i = 0; i < NFLAG; i++) begin
			state_d.flags[i] = (state_q.flags[i] & ~flagClr[i]) | flagSet[i];
		end

		state_d.wake   = wakeNext;
		state_d.byPkt  = byPktNext;
		state_d.pinOe  = 1'b1;
		state_d.pinOut = waveBit;
		state_d.irq    = |(state_d.flags & state_d.irqEn);

		// synchronous reset; the strap keeps following the pin while held
		if (rst) begin
			state_d.strap     = state_q.pinS2;
			state_d.contender = state_q.pinS2;
			state_d.linkCtrl  = CTRL_LINK_ACT_RST;
			state_d.resumeEn  = CTRL_RESUME_EN_RST;
			state_d.flags     = FLAGS_RST;
			state_d.irqEn     = IRQEN_RST;
			state_d.wake      = 1'b0;
			state_d.byPkt     = 1'b0;
			state_d.pinOe     = 1'b0;
			state_d.pinOut    = 1'b0;
			state_d.irq       = 1'b0;
			state_d.prdata    = 32'h0000_0000;
			state_d.pready    = 1'b0;
			state_d.pslverr   = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		state_q <= state_d;
	end

	// outputs straight from the state flops
	assign prdata          = state_q.prdata;
	assign pready          = state_q.pready;
	assign pslverr         = state_q.pslverr;
	assign wakePinOut      = state_q.pinOut;
	assign wakePinOe       = state_q.pinOe;
	assign contenderStatus = state_q.contender;
	assign irq             = state_q.irq;

	// pin released while reset is held
	property p_hiz_reset;
		@(posedge clk_sys)
		rst |=> !wakePinOe;
	endproperty
	a_hiz_reset: assert property (p_hiz_reset) else $error("pin driven during reset");

	// contender taken from the synchronised pin at the last reset cycle
	property p_strap;
		@(posedge clk_sys)
		$fell(rst) |-> (contenderStatus == $past(state_q.pinS2));
	endproperty
	a_strap: assert property (p_strap) else $error("contender not strapped");

	// pin driven from the second cycle after release onward
	property p_drive_after;
		@(posedge clk_sys) disable iff (rst)
		$past(rst) == 1'b0 |-> wakePinOe;
	endproperty
	a_drive_after: assert property (p_drive_after) else $error("pin not driven");

	// idle wake keeps the pin low
	property p_idle_low;
		@(posedge clk_sys) disable iff (rst)
		(!state_q.wake)[*3] |-> !wakePinOut;
	endproperty
	a_idle_low: assert property (p_idle_low) else $error("pin not low while idle");

	// an active link layer stops wake on the next edge
	property p_link_stop;
		@(posedge clk_sys) disable iff (rst)
		pwrActive && state_q.linkCtrl |=> !state_q.wake;
	endproperty
	a_link_stop: assert property (p_link_stop) else $error("wake with link active");

	// matching link-on packet starts wake
	property p_pkt_wake;
		@(posedge clk_sys) disable iff (rst)
		linkOnRx && linkOnPhyId == nodeId && !linkActive |=> state_q.wake;
	endproperty
	a_pkt_wake: assert property (p_pkt_wake) else $error("link-on packet ignored");

	// port-event flag starts wake
	property p_port_wake;
		@(posedge clk_sys) disable iff (rst)
		state_q.flags[FLG_PORT] && !linkActive |=> state_q.wake;
	endproperty
	a_port_wake: assert property (p_port_wake) else $error("port event ignored");

	// gated timeout and power flags start wake
	property p_resume_wake;
		@(posedge clk_sys) disable iff (rst)
		(state_q.flags[FLG_CFG] || state_q.flags[FLG_CPS] || state_q.flags[FLG_STO])
			&& state_q.resumeEn && !linkActive |=> state_q.wake;
	endproperty
	a_resume_wake: assert property (p_resume_wake) else $error("enabled flag ignored");

	// timeout flags alone, without the enable, never start wake
	property p_resume_gate;
		@(posedge clk_sys) disable iff (rst)
		!state_q.wake && !state_q.resumeEn && !state_q.flags[FLG_PORT] && !linkOnRx
			|=> !state_q.wake;
	endproperty
	a_resume_gate: assert property (p_resume_gate) else $error("wake without cause");

	// wake holds while the link stays idle and no bus reset comes
	property p_hold;
		@(posedge clk_sys) disable iff (rst)
		state_q.wake && !linkActive && !busReset |=> state_q.wake;
	endproperty
	a_hold: assert property (p_hold) else $error("wake dropped early");

	// bus reset ends a packet-only wake
	property p_bus_reset;
		@(posedge clk_sys) disable iff (rst)
		busReset && !irqWake && !pktMatch |=> !state_q.wake;
	endproperty
	a_bus_reset: assert property (p_bus_reset) else $error("bus reset kept wake");

	// bus reset keeps wake while an enabled flag asks for it
	property p_bus_keep;
		@(posedge clk_sys) disable iff (rst)
		busReset && irqWake && !linkActive |=> state_q.wake;
	endproperty
	a_bus_keep: assert property (p_bus_keep) else $error("bus reset dropped irq wake");

	// interrupt output follows enabled sticky bits
	property p_irq_level;
		@(posedge clk_sys) disable iff (rst)
		|(state_q.flags & state_q.irqEn) |-> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq low with enabled flag");

	// interrupt output drops once no enabled sticky bit is left
	property p_irq_clear;
		@(posedge clk_sys) disable iff (rst)
		!(|(state_q.flags & state_q.irqEn)) |-> !irq;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("irq high with no enabled flag");

	// pin carries the wave one register stage later, never a raw level
	property p_pin_wave;
		@(posedge clk_sys) disable iff (rst)
		wakePinOe |=> wakePinOut == $past(waveBit);
	endproperty
	a_pin_wave: assert property (p_pin_wave) else $error("pin does not follow wave");

	// a matching link-on packet is recorded in its sticky bit
	property p_pkt_flag;
		@(posedge clk_sys) disable iff (rst)
		pktMatch |=> state_q.flags[FLG_LINK_ON];
	endproperty
	a_pkt_flag: assert property (p_pkt_flag) else $error("link-on packet not recorded");

	// after reset only a software write may change the contender bit
	property p_cont_hold;
		@(posedge clk_sys) disable iff (rst)
		!(apbWr && paddr == OFS_CTRL) |=> $stable(contenderStatus);
	endproperty
	a_cont_hold: assert property (p_cont_hold) else $error("contender changed unasked");

	// one wait state: never ready in the first access cycle after setup
	property p_apb_setup;
		@(posedge clk_sys) disable iff (rst)
		psel && !penable |=> !pready;
	endproperty
	a_apb_setup: assert property (p_apb_setup) else $error("ready in setup cycle");

	// ready is a single-cycle pulse per access
	property p_apb_pulse;
		@(posedge clk_sys) disable iff (rst)
		pready |=> !pready;
	endproperty
	a_apb_pulse: assert property (p_apb_pulse) else $error("ready held too long");
endmodule : lows_link_on_wake

// ### lows_llc_model.sv
// lows_llc_model: link layer stand-in that drives the power status pin.
// assumes it sees the resolved shared pin and is commanded by the bench.
`timescale 1ns/1ps
module lows_llc_model #(
	parameter int WAKE_EDGES = 3
) (
	input  wire logic clk_sys,
	input  wire logic wakeLine,
	input  wire logic goSleep,
	input  wire logic answer,
	output logic      linkPowerStatus
);
	logic prevQ;
	int   edgeCnt;

	// starts powered; the bench lets it power up only after real wake edges
	initial begin
		linkPowerStatus = 1'b1;
		prevQ           = 1'b0;
		edgeCnt         = 0;
	end

	// a stuck pin never wakes it: rising edges are counted, not levels
	always @(posedge clk_sys) begin
		prevQ <= wakeLine;
		if (goSleep) begin
			linkPowerStatus <= 1'b0;
			edgeCnt         <= 0;
		end else if (answer && !linkPowerStatus && wakeLine && !prevQ) begin
			edgeCnt <= edgeCnt + 1;
			if (edgeCnt == WAKE_EDGES - 1) linkPowerStatus <= 1'b1;
		end
	end
endmodule : lows_llc_model

// ### lows_link_on_wake_tb.sv
// lows_link_on_wake_tb: register and pin test of the wake pin block.
// assumes lows_llc_model on the power status pin and a strap on the shared pin.
`timescale 1ns/1ps
module lows_link_on_wake_tb;
	import lows_pkg::*;
	localparam logic [5:0] MY_ID = 6'h05;
	logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
	logic        wakePinOut, wakePinOe, linkPowerStatus, contenderStatus, irq;
	logic        strap, goSleep, answer, rerr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [5:0]  ev, linkOnPhyId;
	wire logic   wakePinIn;
	int          mismatches, checks_done, i;

	// the strap resistor only wins while the block leaves the pin undriven
	assign wakePinIn = wakePinOe ? wakePinOut : strap;

	lows_link_on_wake dut_u (
		.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .wakePinIn, .wakePinOut, .wakePinOe, .linkPowerStatus,
		.linkOnPhyId, .linkOnRx(ev[4]), .nodeId(MY_ID), .busReset(ev[5]),
		.portEventSet(ev[0]), .configTimeoutSet(ev[1]), .cablePowerSet(ev[2]),
		.stateTimeoutSet(ev[3]), .contenderStatus, .irq
	);

	lows_llc_model #(.WAKE_EDGES(3)) llc_u (
		.clk_sys, .wakeLine(wakePinIn), .goSleep, .answer, .linkPowerStatus
	);

	// 25 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task summarize;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask : chk

	// one apb transfer, then one idle edge so the next setup never collides
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			mismatches++;
			summarize();
		end
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), e, rdat);
	endtask : rd

	// event strobes are one cycle wide
	task pulse(input logic [5:0] e);
		ev <= e;
		@(posedge clk_sys);
		ev <= 6'h00;
		@(posedge clk_sys);
	endtask : pulse

	// did the pin go high at any edge within n cycles
	task expWake(input logic e, input int n);
		logic s;
		s = 1'b0;
		repeat (n) begin
			@(posedge clk_sys);
			if (wakePinOut === 1'b1) s = 1'b1;
		end
		chk("wake seen", 32'(e), 32'(s));
	endtask : expWake

	// catch the first high sample, then 16 samples must read 4 high, 4 low
	task waveChk;
		int n;
		logic [15:0] pat;
		for (n = 0; n < 40 && wakePinOut !== 1'b1; n++) @(posedge clk_sys);
		pat = 16'h0000;
		for (n = 0; n < 16; n++) begin
			pat = {pat[14:0], wakePinOut};
			@(posedge clk_sys);
		end
		chk("wave", 32'h0000F0F0, {16'h0000, pat});
	endtask : waveChk

	task doReset(input logic s);
		strap <= s;
		rst   <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk("oe in reset", 32'h0, 32'(wakePinOe));
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("oe", 32'h1, 32'(wakePinOe));
		chk("pin idle", 32'h0, 32'(wakePinOut));
		chk("contender", 32'(s), 32'(contenderStatus));
	endtask : doReset

	// main sequence
	initial begin
		{rst, psel, penable, pwrite, goSleep, answer} = 6'h20;
		paddr = 8'h00;
		pwdata = 32'h0;
		ev = 6'h00;
		linkOnPhyId = 6'h00;
		strap = 1'b1;
		mismatches = 0;
		checks_done = 0;
		@(posedge clk_sys);
		doReset(1'b1);
		rd(OFS_CTRL, 32'h4);
		rd(OFS_IRQEN, 32'h0);
		rd(OFS_STATUS, 32'h0);
		$display("test reset done");
		// port event while the link layer is off, then interrupt mask and clear
		pulse(6'h01);
		waveChk();
		rd(OFS_STATUS, 32'h21);
		wr(OFS_IRQEN, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk("irq on", 32'h1, 32'(irq));
		wr(OFS_IRQEN, 32'h0);
		repeat (2) @(posedge clk_sys);
		chk("irq masked", 32'h0, 32'(irq));
		wr(OFS_IRQEN, 32'h1);
		wr(OFS_CTRL, 32'h1);
		repeat (4) @(posedge clk_sys);
		expWake(1'b0, 16);
		wr(OFS_CLEAR, 32'h3F);
		repeat (2) @(posedge clk_sys);
		chk("irq cleared", 32'h0, 32'(irq));
		rd(OFS_STATUS, 32'h0);
		$display("test port event done");
		// a flag raised while linked waits for the link to drop
		pulse(6'h01);
		expWake(1'b0, 20);
		wr(OFS_CTRL, 32'h0);
		expWake(1'b1, 24);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_CLEAR, 32'h3F);
		$display("test pending flag done");
		// the three gated flags need the resume enable
		for (i = 1; i < 4; i++) begin
			wr(OFS_CTRL, 32'h0);
			pulse(6'h01 << i);
			expWake(1'b0, 20);
			wr(OFS_CTRL, 32'h2);
			expWake(1'b1, 20);
			wr(OFS_CTRL, 32'h3);
			wr(OFS_CLEAR, 32'h3F);
		end
		$display("test gated flags done");
		// link-on packets and bus reset
		wr(OFS_CTRL, 32'h0);
		linkOnPhyId <= 6'h06;
		pulse(6'h10);
		expWake(1'b0, 20);
		linkOnPhyId <= MY_ID;
		pulse(6'h10);
		expWake(1'b1, 20);
		pulse(6'h20);
		repeat (4) @(posedge clk_sys);
		expWake(1'b0, 16);
		pulse(6'h01);
		expWake(1'b1, 20);
		pulse(6'h20);
		expWake(1'b1, 20);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_CLEAR, 32'h3F);
		$display("test packet done");
		// power status must stay low for the filter time before it counts
		goSleep <= 1'b1;
		@(posedge clk_sys);
		goSleep <= 1'b0;
		pulse(6'h01);
		expWake(1'b0, 40);
		expWake(1'b1, 60);
		answer <= 1'b1;
		repeat (60) @(posedge clk_sys);
		expWake(1'b0, 16);
		rd(OFS_STATE, 32'h0E);
		$display("test power status done");
		// read-only, write-only and unmapped places
		wr(OFS_CLEAR, 32'h3F);
		wr(OFS_STATUS, 32'h3F);
		rd(OFS_STATUS, 32'h0);
		rd(OFS_CLEAR, 32'h0);
		rd(8'h20, 32'h0);
		chk("pslverr", 32'h1, 32'(rerr));
		$display("test access done");
		// the strap is taken again at a second reset
		doReset(1'b0);
		rd(OFS_CTRL, 32'h0);
		$display("test second reset done");
		summarize();
	end
endmodule : lows_link_on_wake_tb
